// file: core/lsw_level_filter.sv
// Trigger input level qualifier: a level must stay put before it is believed
`timescale 1ns/100ps
`default_nettype none
module lsw_level_filter #(
    parameter int FILT_W = 16
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              raw_in,
    input  wire logic [FILT_W-1:0] stable_cycles,
    output logic                   level,
    output logic                   valid
);
    logic              last_raw;
    logic [FILT_W-1:0] run;
    logic              next_last_raw;
    logic [FILT_W-1:0] next_run;
    logic              next_level;
    logic              next_valid;

    // ------------------------------------------------------------------
    // Stability counter
    // ------------------------------------------------------------------
    // Any change restarts the count; open input idles high by the pin
    always_comb begin
        next_last_raw = raw_in;
        next_run      = run;
        next_level    = level;
        next_valid    = valid;
        if (raw_in != last_raw) begin
            next_run   = '0;
            next_valid = 1'b0;
        end else if (run + FILT_W'(1) >= stable_cycles) begin
            next_level = raw_in;
            next_valid = 1'b1;
        end else begin
            next_run = run + FILT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_raw <= 1'b1;
            run      <= '0;
            level    <= 1'b1;
            valid    <= 1'b0;
        end else begin
            last_raw <= next_last_raw;
            run      <= next_run;
            level    <= next_level;
            valid    <= next_valid;
        end
    end
endmodule
`default_nettype wire

// file: core/lsw_step_wait.sv
// Trigger-wait step advance for the output list sequencer
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Output takes step value at step entry
// - Trigger input high when one or open
// - High mode holds until input high
// - High already, timeout set: skip step
// - High mode: high or timeout, first wins
// - High mode zero timeout waits forever
// - High mode filter 0.4 ms stable
// - Low mode holds; low plus timeout skips
// - Low mode: low or timeout, first wins
// - Low mode zero timeout waits forever
// - Low mode filter 2 us stable
// - Edge mode needs high then low
// - Edge mode: fall or timeout, first wins
// - Edge mode zero timeout waits forever
// - No list type: settings conflict error
// - High/edge unequal counts: not same length
// - Low unequal counts: unbalanced error
// - Timeout 250 us to 34 ms, zero infinite
module lsw_step_wait
    import lsw_pkg::*;
#(
    parameter int HIGH_CYC = lsw_pkg::HIGH_STABLE_CYC,
    parameter int LOW_CYC  = lsw_pkg::LOW_STABLE_CYC,
    parameter int USEC_CYC = lsw_pkg::US_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         step_start,
    input  wire lsw_pkg::lsw_mode_type        step_mode,
    input  wire logic [lsw_pkg::VALUE_W-1:0]  step_value,
    input  wire lsw_pkg::lsw_list_type        current_list_entry,
    input  wire logic [lsw_pkg::COUNT_W-1:0]  dwell_count,
    input  wire logic [lsw_pkg::COUNT_W-1:0]  value_count,
    input  wire logic [lsw_pkg::TIMEOUT_W-1:0] timeout_us,
    input  wire logic                         trig_in,
    output logic [lsw_pkg::VALUE_W-1:0]       out_value,
    output logic                              busy,
    output logic                              step_advance,
    output logic                              timed_out,
    output logic                              err_valid,
    output logic [15:0]                       err_code
);
    import lsw_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_DONE  = 4'b1000
    } lsw_state_type;

    lsw_state_type            state;
    lsw_state_type            next_state;
    lsw_mode_type             mode;
    lsw_mode_type             next_mode;
    logic [TIMEOUT_W-1:0]     tmo_lim;
    logic [TIMEOUT_W-1:0]     next_tmo_lim;
    logic [TIMEOUT_W-1:0]     us_count;
    logic [TIMEOUT_W-1:0]     next_us_count;
    logic [7:0]               pre;
    logic [7:0]               next_pre;
    logic                     seen_high;
    logic                     next_seen_high;
    logic [VALUE_W-1:0]       next_out_value;
    logic                     next_busy;
    logic                     next_step_advance;
    logic                     next_timed_out;
    logic                     next_err_valid;
    logic [15:0]              next_err_code;
    logic                     hi_level;
    logic                     hi_valid;
    logic                     lo_level;
    logic                     lo_valid;
    logic                     lvl;
    logic                     lvl_ok;
    logic                     tmo_hit;

    // ------------------------------------------------------------------
    // Level qualifiers, one per filter length
    // ------------------------------------------------------------------
    // Two filters run side by side so the mode can change at step entry
    // without waiting for a refilled counter
    lsw_level_filter #(.FILT_W(FILT_W)) u_filt_high (
        .clk           (clk),
        .resetn        (resetn),
        .raw_in        (trig_in),
        .stable_cycles (FILT_W'(HIGH_CYC)),
        .level         (hi_level),
        .valid         (hi_valid)
    );

    lsw_level_filter #(.FILT_W(FILT_W)) u_filt_low (
        .clk           (clk),
        .resetn        (resetn),
        .raw_in        (trig_in),
        .stable_cycles (FILT_W'(LOW_CYC)),
        .level         (lo_level),
        .valid         (lo_valid)
    );

    // Low mode uses the short filter; high and edge modes the long one
    always_comb begin
        lvl    = (mode == MODE_LOW) ? lo_level : hi_level;
        lvl_ok = (mode == MODE_LOW) ? lo_valid : hi_valid;
    end

    // Timeout reached; limit of zero never expires
    assign tmo_hit = (tmo_lim != '0) && (us_count >= tmo_lim);

    // ------------------------------------------------------------------
    // Step sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_mode         = mode;
        next_tmo_lim      = tmo_lim;
        next_us_count     = us_count;
        next_pre          = pre;
        next_seen_high    = seen_high;
        next_out_value    = out_value;
        next_busy         = busy;
        next_step_advance = 1'b0;
        next_timed_out    = 1'b0;
        next_err_valid    = 1'b0;
        next_err_code     = err_code;
        unique case (state)
            ST_IDLE: begin
                if (step_start) begin
                    if (current_list_entry == LIST_NONE) begin
                        next_err_valid = 1'b1;
                        next_err_code  = ERR_CONFLICT;
                    end else if (dwell_count != value_count) begin
                        next_err_valid = 1'b1;
                        next_err_code  = (step_mode == MODE_LOW)
                                         ? ERR_UNBALANCED
                                         : ERR_NOT_SAME;
                    end else begin
                        next_out_value = step_value;
                        next_mode      = step_mode;
                        // Out-of-range values clamp into 250 us..34 ms
                        if (timeout_us == '0) begin
                            next_tmo_lim = '0;
                        end else if (timeout_us < TIMEOUT_W'(TIMEOUT_MIN_US))
                        begin
                            next_tmo_lim = TIMEOUT_W'(TIMEOUT_MIN_US);
                        end else if (timeout_us > TIMEOUT_W'(TIMEOUT_MAX_US))
                        begin
                            next_tmo_lim = TIMEOUT_W'(TIMEOUT_MAX_US);
                        end else begin
                            next_tmo_lim = timeout_us;
                        end
                        next_us_count  = '0;
                        next_pre       = '0;
                        next_seen_high = 1'b0;
                        next_busy      = 1'b1;
                        next_state     = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // Input already at target with timeout set: skip at once
                if (lvl_ok && tmo_lim != '0 &&
                    ((mode == MODE_HIGH && lvl) ||
                     (mode == MODE_LOW && !lvl))) begin
                    next_state = ST_DONE;
                end else begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Microsecond prescaler feeds the timeout count
                if (pre == 8'(USEC_CYC - 1)) begin
                    next_pre      = '0;
                    next_us_count = us_count + TIMEOUT_W'(1);
                end else begin
                    next_pre = pre + 8'(1);
                end
                if (lvl_ok && lvl) begin
                    next_seen_high = 1'b1;
                end
                unique case (mode)
                    MODE_HIGH: begin
                        if (lvl_ok && lvl) begin
                            next_state = ST_DONE;
                        end else if (tmo_hit) begin
                            next_timed_out = 1'b1;
                            next_state     = ST_DONE;
                        end
                    end
                    MODE_LOW: begin
                        if (lvl_ok && !lvl) begin
                            next_state = ST_DONE;
                        end else if (tmo_hit) begin
                            next_timed_out = 1'b1;
                            next_state     = ST_DONE;
                        end
                    end
                    default: begin
                        // Falling edge only counts after a qualified high
                        if (seen_high && lvl_ok && !lvl) begin
                            next_state = ST_DONE;
                        end else if (tmo_hit) begin
                            next_timed_out = 1'b1;
                            next_state     = ST_DONE;
                        end
                    end
                endcase
            end
            ST_DONE: begin
                next_step_advance = 1'b1;
                next_busy         = 1'b0;
                next_us_count     = '0;
                next_pre          = '0;
                next_state        = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
                next_busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state        <= ST_IDLE;
            mode         <= MODE_HIGH;
            tmo_lim      <= '0;
            us_count     <= '0;
            pre          <= '0;
            seen_high    <= 1'b0;
            out_value    <= OUT_RESET;
            busy         <= 1'b0;
            step_advance <= 1'b0;
            timed_out    <= 1'b0;
            err_valid    <= 1'b0;
            err_code     <= ERR_NONE;
        end else begin
            state        <= next_state;
            mode         <= next_mode;
            tmo_lim      <= next_tmo_lim;
            us_count     <= next_us_count;
            pre          <= next_pre;
            seen_high    <= next_seen_high;
            out_value    <= next_out_value;
            busy         <= next_busy;
            step_advance <= next_step_advance;
            timed_out    <= next_timed_out;
            err_valid    <= next_err_valid;
            err_code     <= next_err_code;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_value_at_entry: assert property (
        (state == ST_IDLE && step_start && current_list_entry != LIST_NONE
         && dwell_count == value_count) |=> out_value == $past(step_value))
        else $error("step value not applied at entry");
    a_conflict_err: assert property (
        (state == ST_IDLE && step_start && current_list_entry == LIST_NONE)
        |=> err_valid && err_code == ERR_CONFLICT && !busy)
        else $error("missing settings conflict error");
    a_len_err: assert property (
        (state == ST_IDLE && step_start && current_list_entry != LIST_NONE
         && dwell_count != value_count && step_mode != MODE_LOW)
        |=> err_valid && err_code == ERR_NOT_SAME)
        else $error("missing unequal length error");
    a_unbal_err: assert property (
        (state == ST_IDLE && step_start && current_list_entry != LIST_NONE
         && dwell_count != value_count && step_mode == MODE_LOW)
        |=> err_valid && err_code == ERR_UNBALANCED)
        else $error("missing unbalanced error");
    a_high_skip: assert property (
        (state == ST_SETUP && mode == MODE_HIGH && tmo_lim != '0
         && hi_valid && hi_level) |=> ##1 step_advance)
        else $error("high step not skipped");
    a_high_hold: assert property (
        (state == ST_WAIT && mode == MODE_HIGH && !(hi_valid && hi_level)
         && !tmo_hit) |=> state == ST_WAIT)
        else $error("high step left early");
    a_low_done: assert property (
        (state == ST_WAIT && mode == MODE_LOW && lo_valid && !lo_level)
        |=> state == ST_DONE ##1 step_advance)
        else $error("low step did not advance");
    a_zero_tmo: assert property (
        (state == ST_WAIT && tmo_lim == '0) |-> !next_timed_out)
        else $error("timeout with zero limit");
    a_tmo_clear: assert property (
        step_advance |-> us_count == '0)
        else $error("timeout count not cleared");
    a_edge_hold: assert property (
        (state == ST_WAIT && mode == MODE_LEDGE && !seen_high && !tmo_hit)
        |=> state == ST_WAIT)
        else $error("edge step left without high");

    c_high_step: cover property (
        state == ST_WAIT && mode == MODE_HIGH ##2 step_advance);
    c_low_step: cover property (
        state == ST_WAIT && mode == MODE_LOW ##[1:2] step_advance);
    c_edge_step: cover property (step_advance && mode == MODE_LEDGE);
    c_timeout: cover property (timed_out);
endmodule
`default_nettype wire

// file: include/lsw_pkg.sv
// Package for the list step trigger-wait block: modes, error codes, timing
package lsw_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int HIGH_STABLE_NS    = 400_000;   // 0.4 ms filter
    localparam int LOW_STABLE_NS     = 2_000;     // 2 us filter
    localparam int HIGH_STABLE_CYC   = (HIGH_STABLE_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int LOW_STABLE_CYC    = (LOW_STABLE_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    // Timeout is given in microseconds; 0.00025 s to 0.034 s
    localparam int TIMEOUT_MIN_US    = 250;
    localparam int TIMEOUT_MAX_US    = 34_000;
    localparam int US_CYC            = 1_000 / CLK_PERIOD_NS;
    localparam int TIMEOUT_W         = 16;
    localparam int FILT_W            = 16;
    localparam int VALUE_W           = 16;
    localparam int COUNT_W           = 13;

    // ------------------------------------------------------------------
    // Wait modes and list types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_HIGH  = 2'h0,
        MODE_LOW   = 2'h1,
        MODE_LEDGE = 2'h2
    } lsw_mode_type;

    typedef enum logic [1:0] {
        LIST_NONE = 2'h0,
        CURRENT_LIST_ENTRY = 2'h1,
        LIST_VOLT = 2'h2
    } lsw_list_type;

    // Error codes as 16-bit two's complement of the negative numbers
    localparam logic [15:0] ERR_NONE       = 16'h0000;
    localparam logic [15:0] ERR_CONFLICT   = 16'hFF23;   // -221
    localparam logic [15:0] ERR_NOT_SAME   = 16'hFF1E;   // -226
    localparam logic [15:0] ERR_UNBALANCED = 16'hFF14;   // -236

    localparam logic [VALUE_W-1:0] OUT_RESET = 16'h0000;

endpackage

// file: tb/list_step_trigger_wait_tb_top.sv
// Self-checking bench for the trigger-wait step block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
    end \
end
module list_step_trigger_wait_tb_top;
    import lsw_pkg::*;

    localparam int USEC = 2;

    logic                 clk;
    logic                 resetn;
    logic                 step_start;
    lsw_mode_type         step_mode;
    logic [VALUE_W-1:0]   step_value;
    lsw_list_type         current_list_entry;
    logic [COUNT_W-1:0]   dwell_count;
    logic [COUNT_W-1:0]   value_count;
    logic [TIMEOUT_W-1:0] timeout_us;
    logic                 trig_in;
    logic                 req;
    logic [VALUE_W-1:0]   out_value;
    logic                 busy;
    logic                 step_advance;
    logic                 timed_out;
    logic                 err_valid;
    logic [15:0]          err_code;
    int                   num_errors;
    int                   comparisons;
    int                   cyc;

    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    // Short filters and microsecond keep the run brief
    lsw_step_wait #(
        .HIGH_CYC (20),
        .LOW_CYC  (5),
        .USEC_CYC (USEC)
    ) lsw_step_wait_inst (
        .clk                (clk),
        .resetn             (resetn),
        .step_start         (step_start),
        .step_mode          (step_mode),
        .step_value         (step_value),
        .current_list_entry (current_list_entry),
        .dwell_count        (dwell_count),
        .value_count        (value_count),
        .timeout_us         (timeout_us),
        .trig_in            (trig_in),
        .out_value          (out_value),
        .busy               (busy),
        .step_advance       (step_advance),
        .timed_out          (timed_out),
        .err_valid          (err_valid),
        .err_code           (err_code)
    );

    lsw_trig_source #(
        .HOLD (25)
    ) lsw_trig_source_inst (
        .clk       (clk),
        .req_level (req),
        .trig_out  (trig_in)
    );

    // ------------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------------
    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hung wait step would otherwise never end the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------------
    function automatic logic [15:0] exp_err(lsw_mode_type m, lsw_list_type l,
                                            logic [COUNT_W-1:0] d,
                                            logic [COUNT_W-1:0] v);
        if (l == LIST_NONE) return ERR_CONFLICT;
        if (d != v) return (m == MODE_LOW) ? ERR_UNBALANCED : ERR_NOT_SAME;
        return ERR_NONE;
    endfunction

    // Nonzero limits below the minimum are raised to it
    function automatic int exp_tmo(int t);
        return ((t < TIMEOUT_MIN_US) ? TIMEOUT_MIN_US : t) * USEC;
    endfunction

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic start(input lsw_mode_type m, input lsw_list_type l,
                         input logic [COUNT_W-1:0] d,
                         input logic [COUNT_W-1:0] v, input int t);
        @(negedge clk);
        step_mode          = m;
        current_list_entry = l;
        dwell_count        = d;
        value_count        = v;
        timeout_us         = TIMEOUT_W'(t);
        step_value         = VALUE_W'($urandom);
        step_start         = 1'b1;
        @(negedge clk);
        step_start = 1'b0;
    endtask

    // Counts cycles from the one after the taking edge
    task automatic watch(input int lim, output int n, output logic adv,
                         output logic tmo, output logic ev);
        n   = 0;
        adv = 1'b0;
        tmo = 1'b0;
        ev  = 1'b0;
        while (1) begin
            if (timed_out === 1'b1) tmo = 1'b1;
            if (step_advance === 1'b1) adv = 1'b1;
            if (err_valid === 1'b1) ev = 1'b1;
            if (adv || ev || n >= lim) break;
            @(negedge clk);
            n++;
        end
    endtask

    task automatic settle(input logic lv);
        req <= lv;
        repeat (50) @(negedge clk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int                 n;
        logic               adv;
        logic               tmo;
        logic               ev;
        lsw_mode_type       m;
        lsw_list_type       l;
        logic [COUNT_W-1:0] d;
        logic [COUNT_W-1:0] v;
        logic [15:0]        exp_code;
        int                 exp_n;
        resetn             = 1'b0;
        step_start         = 1'b0;
        step_mode          = MODE_HIGH;
        step_value         = '0;
        current_list_entry = LIST_NONE;
        dwell_count        = '0;
        value_count        = '0;
        timeout_us         = '0;
        req                = 1'b1;
        void'($urandom(32'h9086_0c94));
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        // Refused steps: missing list type or unequal counts
        for (int i = 0; i < 12; i++) begin
            m = lsw_mode_type'(i % 3);
            l = lsw_list_type'($urandom_range(0, 2));
            d = COUNT_W'($urandom);
            v = (l == LIST_NONE && i[1]) ? d : d ^ COUNT_W'(i + 1);
            start(m, l, d, v, 1);
            watch(4, n, adv, tmo, ev);
            `CHK("err_valid", 1'b1, ev)
            exp_code = exp_err(m, l, d, v);
            `CHK("err_code", exp_code, err_code)
            `CHK("busy", 1'b0, busy)
        end
        // High already qualified, timeout set: skipped at once
        settle(1'b1);
        start(MODE_HIGH, LIST_VOLT, 13'h0005, 13'h0005, 1);
        `CHK("out_value", step_value, out_value)
        watch(6, n, adv, tmo, ev);
        `CHK("skip", 1'b1, adv && n <= 3)
        // High wait with zero timeout: held until a qualified high
        settle(1'b0);
        start(MODE_HIGH, CURRENT_LIST_ENTRY, 13'h0007, 13'h0007, 0);
        `CHK("out_value", step_value, out_value)
        `CHK("busy", 1'b1, busy)
        watch(60, n, adv, tmo, ev);
        `CHK("held", 1'b0, adv)
        req <= 1'b1;
        watch(100, n, adv, tmo, ev);
        `CHK("advance", 1'b1, adv)
        `CHK("filtered", 1'b1, n >= 20)
        `CHK("timed_out", 1'b0, tmo)
        // High wait with timeout, input stays low; back to back
        settle(1'b0);
        for (int t = 1; t <= 301; t += 300) begin
            start(MODE_HIGH, LIST_VOLT, 13'h0003, 13'h0003, t);
            watch(800, n, adv, tmo, ev);
            `CHK("advance", 1'b1, adv)
            `CHK("timed_out", 1'b1, tmo)
            exp_n = exp_tmo(t);
            `CHK("tmo_len", 1'b1, n >= exp_n && n <= exp_n + 6)
        end
        // Low already qualified, timeout set: skipped
        start(MODE_LOW, CURRENT_LIST_ENTRY, 13'h0009, 13'h0009, 1);
        watch(6, n, adv, tmo, ev);
        `CHK("skip", 1'b1, adv && n <= 3)
        // Low wait with zero timeout
        settle(1'b1);
        start(MODE_LOW, LIST_VOLT, 13'h0002, 13'h0002, 0);
        `CHK("out_value", step_value, out_value)
        watch(60, n, adv, tmo, ev);
        `CHK("held", 1'b0, adv)
        req <= 1'b0;
        watch(40, n, adv, tmo, ev);
        `CHK("advance", 1'b1, adv)
        `CHK("filtered", 1'b1, n >= 5)
        // Edge wait starting low: needs high then low
        start(MODE_LEDGE, CURRENT_LIST_ENTRY, 13'h0004, 13'h0004, 0);
        watch(60, n, adv, tmo, ev);
        `CHK("held", 1'b0, adv)
        req <= 1'b1;
        watch(60, n, adv, tmo, ev);
        `CHK("held_high", 1'b0, adv)
        req <= 1'b0;
        watch(60, n, adv, tmo, ev);
        `CHK("advance", 1'b1, adv)
        // Edge wait with timeout and no falling edge
        settle(1'b1);
        start(MODE_LEDGE, LIST_VOLT, 13'h0006, 13'h0006, 1);
        watch(800, n, adv, tmo, ev);
        `CHK("timed_out", 1'b1, adv && tmo)
        print_verdict();
    end
endmodule
`default_nettype wire

// file: tb/lsw_trig_source.sv
// Behavioural model of the external trigger pulse source
`timescale 1ns/100ps
`default_nettype none
module lsw_trig_source #(
    parameter int HOLD = 25
) (
    input  wire logic clk,
    input  wire logic req_level,
    output var  logic trig_out
);
    int unsigned held;

    // ------------------------------------------------------------------
    // Level driver
    // ------------------------------------------------------------------
    // An open input reads high, so the line starts high
    initial begin
        trig_out = 1'b1;
        held     = 0;
    end

    // A level is kept for HOLD cycles before the next one, longer than
    // either qualifier, so no level is shorter than the filter wants
    always @(negedge clk) begin
        if (req_level !== trig_out && held >= HOLD) begin
            trig_out <= req_level;
            held     <= 0;
        end else if (held < HOLD) begin
            held <= held + 1;
        end
    end
endmodule
`default_nettype wire
